// *** pkg/cie_pkg.sv ***
// Constants, field layouts and carrier types for the event entry unit.
package cie_pkg;

  // ********************************************************
  // Register offsets on the APB slave
  // ********************************************************
  localparam logic [11:0] CIE_OFF_STATUS = 12'h000;
  localparam logic [11:0] CIE_OFF_STACK = 12'h004;
  localparam logic [11:0] CIE_OFF_TABLE = 12'h008;
  localparam logic [11:0] CIE_OFF_ENTRY = 12'h00C;

  // ********************************************************
  // Program status word layout
  // ********************************************************
  localparam int CIE_PS_MASK_LSB = 16;
  localparam int CIE_PS_SSEL_BIT = 5;
  localparam int CIE_PS_GIE_BIT = 4;
  localparam int CIE_PS_MASK_HI = 4;

  // ********************************************************
  // Values after reset
  // ********************************************************
  localparam logic [4:0] CIE_RST_MASK = 5'h0F;
  localparam logic [31:0] CIE_RST_TABLE = 32'h000FFC00;
  localparam logic [31:0] CIE_RST_STACK = 32'h00000000;

  // ********************************************************
  // Entry arithmetic and timing
  // ********************************************************
  localparam logic [31:0] CIE_FRAME_BYTES = 32'h00000008;
  localparam logic [31:0] CIE_WORD_BYTES = 32'h00000004;
  localparam logic [9:0] CIE_VEC_NMI = 10'h3C0;
  localparam logic [9:0] CIE_VEC_UNDEF = 10'h3C4;
  localparam logic [9:0] CIE_VEC_USER_TOP = 10'h3FC;
  localparam logic [4:0] CIE_NMI_MASK = 5'h0F;
  localparam logic [3:0] CIE_UNDEF_ENTRY_CYC = 4'h7;
  localparam logic [3:0] CIE_INT_ENTRY_EXTRA = 4'h6;

  typedef enum logic [2:0] {
    CIE_IDLE, CIE_PUSH_PS, CIE_PUSH_RET, CIE_READ_VEC, CIE_LAUNCH
  } cie_state_e;

  typedef enum logic [1:0] {
    CIE_NONE, CIE_USER, CIE_NMI, CIE_UNDEF
  } cie_cause_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cie_mem_s;

  typedef struct packed {
    logic valid;
    logic [4:0] level;
    logic [7:0] vec_num;
  } cie_irq_s;

  typedef struct packed {
    cie_state_e state;
    cie_cause_e cause;
    logic [3:0] cnt;
    logic [4:0] mask;
    logic ssel;
    logic gie;
    logic [3:0] cc;
    logic [31:0] sys_stack_ptr;
    logic [31:0] table_base;
    logic [31:0] ps_save;
    logic [31:0] ret_addr;
    logic [9:0] vec_off;
    logic nmi_prev;
    logic nmi_pend;
    cie_mem_s mem;
    logic flush;
    logic redirect;
    logic [31:0] redir_addr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cie_regs_s;

endpackage

// *** core/cie_entry.sv ***
// Interrupt and exception entry unit with its APB register slave.
//
// What this block does
// - User interrupt taken when requested, level below mask, and global enable set.
// - User entry pushes status and next address, stack minus 8, mask gets level.
// - User entry starts within n plus 6 cycles, plus memory waits.
// - On entry younger instructions are flushed; cancelled instruction address is stacked.
// - Unmaskable request ignores global enable; software cannot mask it.
// - Unmaskable request taken only while mask exceeds 15.
// - Unmaskable pin: falling edge normally, low level in stop mode.
// - Unmaskable entry pushes frame, mask becomes 15, vector at base plus 3C0.
// - Unmaskable entry starts within n plus 6 cycles, plus memory waits.
// - Exception enters before the faulting instruction runs; its address is stacked.
// - Undefined code pushes status and own address, vector at base plus 3C4.
// - Undefined-code entry takes at least 7 cycles before the handler starts, more after three memory waits.
// - Undefined code in a delay slot acts as a no-operation.
// - Frame goes where the system stack pointer points, whatever stack select says.
// - The vector table is 1 Kbyte from the table base.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module cie_entry #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cie_pkg::cie_irq_s irq,
  input wire logic nmi_n,
  input wire logic stop_mode,
  input wire logic insn_start,
  input wire logic [31:0] insn_addr,
  input wire logic undef_insn,
  input wire logic delay_slot,
  output cie_pkg::cie_mem_s mem_out,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic entry_busy,
  output logic pipe_flush,
  output logic redirect,
  output logic [31:0] redirect_addr,
  output logic [4:0] level_mask,
  output logic global_int_enable,
  output logic stack_select
);
  import cie_pkg::*;

  cie_regs_s r;
  cie_regs_s n;
  logic nmi_hit;
  logic wr;
  logic [11:0] off;
  cie_cause_e take;

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic [31:0] ps_pack(input cie_regs_s s);
    logic [31:0] v;
    v = 32'h00000000;
    v[CIE_PS_MASK_LSB +: 5] = s.mask;
    v[CIE_PS_SSEL_BIT] = s.ssel;
    v[CIE_PS_GIE_BIT] = s.gie;
    v[3:0] = s.cc;
    return v;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return a == CIE_OFF_STATUS || a == CIE_OFF_STACK ||
           a == CIE_OFF_TABLE || a == CIE_OFF_ENTRY;
  endfunction

  assign off = 12'(paddr);

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    n = r;
    n.flush = 1'b0;
    n.redirect = 1'b0;
    take = CIE_NONE;

    // The pin is sampled once per edge; the previous sample gives the edge.
    nmi_hit = stop_mode ? ~nmi_n : (r.nmi_prev & ~nmi_n);
    n.nmi_prev = nmi_n;

    // APB: zero-wait access, data latched during the setup cycle.
    n.pready = psel & ~penable & ~r.pready;
    if (psel & ~penable) begin
      n.pslverr = ~mapped(off);
      unique case (off)
        CIE_OFF_STATUS: n.prdata = ps_pack(r);
        CIE_OFF_STACK: n.prdata = r.sys_stack_ptr;
        CIE_OFF_TABLE: n.prdata = r.table_base;
        CIE_OFF_ENTRY: n.prdata = {25'h0000000, r.nmi_pend, r.cause,
                                   (r.state != CIE_IDLE), 3'h0};
        default: n.prdata = 32'h00000000;
      endcase
    end
    wr = psel & penable & r.pready & pwrite;
    if (wr) begin
      unique case (off)
        CIE_OFF_STATUS: begin
          // Software may raise the top mask bit but never clear it.
          n.mask = pwdata[CIE_PS_MASK_LSB +: 5];
          n.mask[CIE_PS_MASK_HI] = pwdata[CIE_PS_MASK_LSB + CIE_PS_MASK_HI]
                                   | r.mask[CIE_PS_MASK_HI];
          n.ssel = pwdata[CIE_PS_SSEL_BIT];
          n.gie = pwdata[CIE_PS_GIE_BIT];
          n.cc = pwdata[3:0];
        end
        CIE_OFF_STACK: n.sys_stack_ptr = {pwdata[31:2], 2'b00};
        CIE_OFF_TABLE: n.table_base = {pwdata[31:10], 10'h000};
        default: ;
      endcase
    end

    if (r.state != CIE_IDLE && r.cnt != 4'hF) begin
      n.cnt = r.cnt + 4'h1;
    end

    // ********************************************************
    // Entry sequence
    // ********************************************************
    unique case (r.state)
      CIE_IDLE: begin
        if (insn_start) begin
          if (undef_insn && !delay_slot) begin
            take = CIE_UNDEF;
          end else if (r.nmi_pend && r.mask > CIE_NMI_MASK) begin
            take = CIE_NMI;
          end else if (irq.valid && irq.level < r.mask && r.gie) begin
            take = CIE_USER;
          end
        end
        if (take != CIE_NONE) begin
          n.cause = take;
          n.cnt = 4'h1;
          n.state = CIE_PUSH_PS;
          n.flush = 1'b1;
          n.ps_save = ps_pack(r);
          // The instruction now starting is cancelled or faulting.
          n.ret_addr = insn_addr;
          n.sys_stack_ptr = r.sys_stack_ptr - CIE_FRAME_BYTES;
          n.ssel = 1'b0;
          n.mem.req = 1'b1;
          n.mem.we = 1'b1;
          n.mem.addr = r.sys_stack_ptr - CIE_WORD_BYTES;
          n.mem.wdata = ps_pack(r);
          unique case (take)
            CIE_UNDEF: n.vec_off = CIE_VEC_UNDEF;
            CIE_NMI: begin
              n.mask = CIE_NMI_MASK;
              n.vec_off = CIE_VEC_NMI;
            end
            default: begin
              n.mask = irq.level;
              n.vec_off = CIE_VEC_USER_TOP - {irq.vec_num, 2'b00};
            end
          endcase
        end
      end
      CIE_PUSH_PS: begin
        if (mem_ack) begin
          n.state = CIE_PUSH_RET;
          n.mem.addr = r.sys_stack_ptr;
          n.mem.wdata = r.ret_addr;
        end
      end
      CIE_PUSH_RET: begin
        if (mem_ack) begin
          n.state = CIE_READ_VEC;
          n.mem.we = 1'b0;
          n.mem.wdata = 32'h00000000;
          n.mem.addr = r.table_base + {22'h000000, r.vec_off};
        end
      end
      CIE_READ_VEC: begin
        if (mem_ack) begin
          n.state = CIE_LAUNCH;
          n.mem.req = 1'b0;
          n.redir_addr = mem_rdata;
        end
      end
      CIE_LAUNCH: begin
        // Exceptions are padded to a minimum latency of 7 cycles; interrupts leave at once.
        if (r.cause != CIE_UNDEF || r.cnt >= CIE_UNDEF_ENTRY_CYC - 4'h1) begin
          n.redirect = 1'b1;
          n.state = CIE_IDLE;
        end
      end
    endcase

    // A new edge in the cycle the request is taken stays pending.
    if (take == CIE_NMI) begin
      n.nmi_pend = 1'b0;
    end
    if (nmi_hit) begin
      n.nmi_pend = 1'b1;
    end
  end

  // ********************************************************
  // State register
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.state <= CIE_IDLE;
      r.cause <= CIE_NONE;
      r.mask <= CIE_RST_MASK;
      r.sys_stack_ptr <= CIE_RST_STACK;
      r.table_base <= CIE_RST_TABLE;
      r.nmi_prev <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign mem_out = r.mem;
  assign entry_busy = (r.state != CIE_IDLE);
  assign pipe_flush = r.flush;
  assign redirect = r.redirect;
  assign redirect_addr = r.redir_addr;
  assign level_mask = r.mask;
  assign global_int_enable = r.gie;
  assign stack_select = r.ssel;

endmodule // cie_entry

// *** verif/cie_entry_asserts.sv ***
// Port-level checks for the event entry unit.
`timescale 1ns/1ns
module cie_entry_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire cie_pkg::cie_irq_s irq,
  input wire logic insn_start,
  input wire logic undef_insn,
  input wire logic delay_slot,
  input wire cie_pkg::cie_mem_s mem_out,
  input wire logic mem_ack,
  input wire logic entry_busy,
  input wire logic pipe_flush,
  input wire logic redirect,
  input wire logic [4:0] level_mask,
  input wire logic global_int_enable,
  input wire logic stack_select
);
  import cie_pkg::*;
  // *****
  // Entry sequencing
  // *****
  // A frozen clock enable stretches every sequence, so those cycles are not judged.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);
  logic take;
  assign take = insn_start && !entry_busy;
  a_flush_starts: assert property (pipe_flush |-> $rose(entry_busy))
    else $error("flush without entry start");
  a_status_first: assert property (pipe_flush |-> mem_out.req && mem_out.we)
    else $error("status push missing");
  a_word_order: assert property (pipe_flush && mem_ack |=>
    mem_out.req && mem_out.addr == $past(mem_out.addr) - 32'h4)
    else $error("return word not below status");
  a_entry_bound: assert property (pipe_flush |-> ##[4:60] redirect)
    else $error("handler not reached");
  a_undef_late: assert property (take && undef_insn && !delay_slot |=> !redirect [*6])
    else $error("undefined entry too fast");
  a_user_take: assert property (take && irq.valid && global_int_enable &&
    irq.level < level_mask |=> pipe_flush)
    else $error("user request not taken");
  a_no_entry: assert property (take && !(undef_insn && !delay_slot) &&
    level_mask < 5'h10 && !(irq.valid && global_int_enable && irq.level < level_mask)
    |=> !pipe_flush)
    else $error("entry without cause");
  a_ssel_clear: assert property (redirect |=> !stack_select)
    else $error("stack select kept");
endmodule // cie_entry_asserts
bind cie_entry cie_entry_asserts i_cie_entry_asserts (.pclk, .presetn, .ce, .irq,
  .insn_start, .undef_insn, .delay_slot, .mem_out, .mem_ack, .entry_busy, .pipe_flush,
  .redirect, .level_mask, .global_int_enable, .stack_select);

// *** verif/cie_mem_model.sv ***
// Main memory seen by the entry unit, answering at once or every other cycle.
`timescale 1ns/1ns
module cie_mem_model #(
  parameter logic [31:0] KEY = 32'h5A5A0000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire cie_pkg::cie_mem_s mem,
  output logic ack,
  output logic [31:0] rdata
);
  import cie_pkg::*;
  logic tog_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tog_reg <= 1'b0;
    else tog_reg <= !tog_reg;
  end
  assign ack = mem.req && (!slow || tog_reg);
  // Each word reads as its scrambled address; idle lines carry the inverse, never stale data.
  assign rdata = ack ? (mem.addr ^ KEY) : ~(mem.addr ^ KEY);
endmodule // cie_mem_model

// *** verif/tb.sv ***
// Self-checking bench for the event entry unit.
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module tb;
  import cie_pkg::*;
  localparam logic [31:0] KEY = 32'h5A5A0000;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, insn_addr = '0, prdata, mem_rdata, redirect_addr, rd, a, w32;
  logic pready, pslverr, err, mem_ack, entry_busy, pipe_flush, redirect;
  logic nmi_n = 1'b1, stop_mode = 1'b0, insn_start = 1'b0, undef_insn = 1'b0;
  logic delay_slot = 1'b0, slow = 1'b0, global_int_enable, stack_select;
  logic [4:0] level_mask;
  logic [7:0] vec;
  logic [63:0] w64;
  cie_irq_s irq = '0;
  cie_mem_s mem_out;
  logic [31:0] sp = 32'h00001000;
  logic [63:0] wq[$];
  logic [31:0] rq[$];
  int errors = 0, n_compared = 0;
  integer seed = 32'h8EB3FEAA;
  initial forever #20 pclk = ~pclk;
  cie_entry i_cie_entry (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .nmi_n, .stop_mode, .insn_start, .insn_addr,
    .undef_insn, .delay_slot, .mem_out, .mem_ack, .mem_rdata, .entry_busy, .pipe_flush,
    .redirect, .redirect_addr, .level_mask, .global_int_enable, .stack_select);
  cie_mem_model #(.KEY(KEY)) i_cie_mem_model (.pclk, .presetn, .slow, .mem(mem_out),
    .ack(mem_ack), .rdata(mem_rdata));
  function automatic logic [31:0] stw(logic [4:0] m, logic s, logic g, logic [3:0] c);
    return {11'h000, m, 10'h000, s, g, c};
  endfunction
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ent(input logic u, input logic d);
    @(posedge pclk);
    insn_start <= 1'b1;
    insn_addr <= a;
    undef_insn <= u;
    delay_slot <= d;
    slow <= ($random(seed) % 2) != 0;
    @(posedge pclk);
    insn_start <= 1'b0;
    repeat (2) @(posedge pclk);
    while (entry_busy !== 1'b0) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask
  task automatic exp_ent(input logic [31:0] st, input logic [9:0] off);
    wq.push_back({sp - 32'h4, st});
    wq.push_back({sp - 32'h8, a});
    rq.push_back((32'h00002000 + {22'h0, off}) ^ KEY);
    sp = sp - 32'h8;
  endtask
  task automatic give_verdict();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // *****
  // Result watcher
  // *****
  // An entry nobody expected pops an empty queue, and the mismatch shows it.
  always @(posedge pclk) begin
    if (mem_out.req && mem_out.we && mem_ack) begin
      w64 = wq.pop_front();
      `CHK(({mem_out.addr, mem_out.wdata}), w64)
    end
    if (redirect) begin
      w32 = rq.pop_front();
      `CHK(redirect_addr, w32)
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, CIE_OFF_STACK, sp);
    apb(1'b1, CIE_OFF_TABLE, 32'h00002000);
    apb(1'b0, 12'h010, '0);
    `CHK(({err, rd}), 33'h100000000)
    a = $random(seed);
    vec = a[7:0];
    a = {a[31:2], 2'b00};
    apb(1'b1, CIE_OFF_STATUS, stw(5'h10, 1'b1, 1'b1, 4'hA));
    irq <= '{1'b1, 5'h03, vec};
    exp_ent(stw(5'h10, 1'b1, 1'b1, 4'hA), 10'h3FC - {vec, 2'b00});
    ent(1'b0, 1'b0);
    `CHK(level_mask, 5'h03)
    ent(1'b0, 1'b0);
    apb(1'b1, CIE_OFF_STATUS, stw(5'h10, 1'b0, 1'b0, 4'h0));
    irq <= '{1'b1, 5'h01, vec};
    ent(1'b0, 1'b0);
    irq <= '0;
    apb(1'b1, CIE_OFF_STATUS, stw(5'h05, 1'b0, 1'b0, 4'h3));
    @(posedge pclk);
    `CHK(level_mask, 5'h15)
    nmi_n <= 1'b0;
    exp_ent(stw(5'h15, 1'b0, 1'b0, 4'h3), CIE_VEC_NMI);
    ent(1'b0, 1'b0);
    `CHK(level_mask, 5'h0F)
    apb(1'b1, CIE_OFF_STATUS, stw(5'h1F, 1'b0, 1'b0, 4'h3));
    ent(1'b0, 1'b0);
    stop_mode <= 1'b1;
    exp_ent(stw(5'h1F, 1'b0, 1'b0, 4'h3), CIE_VEC_NMI);
    ent(1'b0, 1'b0);
    stop_mode <= 1'b0;
    nmi_n <= 1'b1;
    apb(1'b1, CIE_OFF_STATUS, stw(5'h0F, 1'b1, 1'b0, 4'h5));
    ent(1'b1, 1'b1);
    exp_ent(stw(5'h0F, 1'b1, 1'b0, 4'h5), CIE_VEC_UNDEF);
    ent(1'b1, 1'b0);
    `CHK(stack_select, 1'b0)
    `CHK(wq.size() + rq.size(), 0)
    give_verdict();
  end
  initial begin
    repeat (4000) @(posedge pclk);
    errors++;
    give_verdict();
  end
endmodule // tb
